// File: rtl/cfg_prog_map.svh
// constants for the configuration word loader and its serial programmer
// assumes a 100 MHz core clock shared by both ends in the bench
`ifndef CFG_PROG_MAP_SVH
`define CFG_PROG_MAP_SVH
`define CLK_NS 10
`define LINK_HALF_NS 120
`define LINK_HALF_CYC ((`LINK_HALF_NS) / (`CLK_NS))
`define NV_WRITE_NS 2000
`define NV_WRITE_CYC ((`NV_WRITE_NS) / (`CLK_NS))
`define CW_LAST_ADDR 24'h015ffe
`define CW1_ERASED 16'h7fff
`define CW2_ERASED 16'hbfff
`define CW2_ERASED_NO_USB 16'hb7ff
`define CW34_ERASED 16'hffff
`define NVM_CW_OP 16'h4003
`define NVM_WR_BIT 15
`define CMD_EXEC 4'h0
`define CMD_VIS_OUT 4'h1
`define MOV_LIT_OPC 4'h2
`define OP_NOP 24'h000000
`define OP_GOTO 24'h040200
`define OP_MOV_LIT_W10 24'h24003a
`define OP_MOV_W10_NVM 24'h883b0a
`define OP_MOV_W0_PAGE 24'h8802a0
`define OP_CLR_W8 24'h200008
`define OP_TBLWTH 24'hbbcb88
`define OP_TBLWTL 24'hbb1386
`define OP_BSET_WR 24'ha8e761
`define OP_MOV_NVM_W2 24'h803b02
`define OP_MOV_W2_VIS 24'h883c22
`define CW1_RSV0_BIT 15
`define CW2_RSV1_BIT 2
`define CW2_RSV0_BIT 14
`define CW2_NOUSB_RSV0_BIT 11
`define CW3_RSV1_BIT 7
`define CW4_RSV1_BIT 9
`define REG_CTRL 4'h0
`define REG_DATA 4'h1
`define REG_STATUS 4'h2
`define REG_READBACK 4'h3
`define CTRL_GO_BIT 4
`define STAT_BUSY_BIT 0
`define STAT_DONE_BIT 1
`define STEP_POLL 5'd20
`define STEP_VIS 5'd25
`define STEP_POLL_END 5'd26
`define STEP_LAST 5'd28
`endif

// File: rtl/cfg_prog_pkg.sv
// types shared by the loader, the programmer and the pin synchroniser
// assumes cfg_prog_map.svh on the include path
`include "cfg_prog_map.svh"
package cfg_prog_pkg;
    typedef enum logic [0:0] {DEV_RELOAD, DEV_RUN} dev_state_e;
    typedef enum logic [1:0] {H_IDLE, H_LOW, H_HIGH} host_state_e;

    typedef struct packed {
        logic q1;
        logic q2;
        logic q3;
        logic level;
        logic rise;
        logic fall;
    } sync_s;

    typedef struct packed {
        dev_state_e state;
        logic [1:0] rl_idx;
        logic [3:0][15:0] nv;
        logic [3:0][15:0] cfg;
        logic [27:0] shreg;
        logic [4:0] bitcnt;
        logic vis_mode;
        logic dout;
        logic oe_n;
        logic [15:0][15:0] wreg;
        logic [7:0] page;
        logic [15:0] nonvolatile_control_register;
        logic [15:0] visi;
        logic [15:0] latch;
        logic [23:0] latch_addr;
        logic [15:0] busy_cnt;
    } dev_s;

    typedef struct packed {
        host_state_e state;
        logic [4:0] step;
        logic [4:0] bitcnt;
        logic [4:0] phase;
        logic [27:0] pkt;
        logic clk_out;
        logic dout;
        logic oe_n;
        logic [1:0] idx;
        logic [15:0] value;
        logic done;
        logic [15:0] rx;
        logic [15:0] readback;
        logic [15:0] rdata;
    } host_s;

    function automatic logic [23:0] cw_addr(input logic [1:0] idx);
        return `CW_LAST_ADDR - {21'h0, idx, 1'b0};
    endfunction
endpackage

// File: rtl/prog_link_if.sv
// serial programming link: clock from the programmer, shared data pin
// the data wire idles high when neither end drives it
`timescale 1ns/1ps
`default_nettype none
interface prog_link_if;
    logic programming_clock_pin;
    logic host_data_out;
    logic host_data_oe_n;
    logic dev_data_out;
    logic dev_data_oe_n;
    logic programming_data_pin;

    assign programming_data_pin = !host_data_oe_n ? host_data_out :
                                  !dev_data_oe_n ? dev_data_out : 1'b1;

    modport device(input programming_clock_pin, input programming_data_pin,
                   output dev_data_out, output dev_data_oe_n);
    modport programmer(output programming_clock_pin, output host_data_out,
                       output host_data_oe_n, input programming_data_pin);
endinterface
`default_nettype wire

// File: rtl/pin_sync.sv
// three-stage synchroniser with agreement filter and edge pulses
// pin comes from outside core_clk's domain
`timescale 1ns/1ps
`default_nettype none
module pin_sync import cfg_prog_pkg::*; (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic pin,
    output logic level,
    output logic rise,
    output logic fall
);
    sync_s st;
    sync_s next_st;

    always_comb begin
        next_st = st;
        next_st.q1 = pin;
        next_st.q2 = st.q1;
        next_st.q3 = st.q2;
        next_st.rise = 1'b0;
        next_st.fall = 1'b0;
        // q1 feeds q2 only; the filter looks at the later stages
        if (st.q2 == st.q3 && st.q3 != st.level) begin
            next_st.level = st.q3;
            next_st.rise = st.q3;
            next_st.fall = !st.q3;
        end
        if (!rst_n) begin
            next_st = '0;
        end
    end

    always_ff @(posedge core_clk) begin
        st <= next_st;
    end

    assign level = st.level;
    assign rise = st.rise;
    assign fall = st.fall;
endmodule
`default_nettype wire

// File: rtl/cfg_device.sv
// device end: nonvolatile configuration words, reset reload into live
// registers, and the serial packet engine that programs them
// assumes the link clock is slow against core_clk (half period >= 8 clk)
//
// The strobed register port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "cfg_prog_map.svh"

module cfg_device import cfg_prog_pkg::*; #(
    parameter bit HAS_USB = 1'b1
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic por_n,
    input wire logic chip_erase,
    prog_link_if.device link,
    output logic [15:0] config_word_one,
    output logic [15:0] config_word_two,
    output logic [15:0] config_word_three,
    output logic [15:0] config_word_four,
    output logic reload_done,
    output logic nv_busy
);
    dev_s st;
    dev_s next_st;
    logic ck_level;
    logic ck_rise;
    logic ck_fall;
    logic din;

    pin_sync clk_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .pin(link.programming_clock_pin),
        .level(ck_level),
        .rise(ck_rise),
        .fall(ck_fall)
    );

    // data has the same latency as the clock, so it is stable at rise
    pin_sync data_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .pin(link.programming_data_pin),
        .level(din),
        .rise(),
        .fall()
    );

    function automatic logic [15:0] erased_value(input logic [1:0] i);
        logic [15:0] v;
        v = `CW34_ERASED;
        if (i == 2'd0) begin
            v = `CW1_ERASED;
        end else if (i == 2'd1) begin
            v = HAS_USB ? `CW2_ERASED : `CW2_ERASED_NO_USB;
        end
        return v;
    endfunction

    // hit flag and word index for a latched table address
    function automatic logic [2:0] cw_slot(input logic [23:0] a);
        logic [2:0] r;
        r = 3'h0;
        for (int i = 0; i < 4; i++) begin
            if (a == cw_addr(2'(i))) begin
                r = {1'b1, 2'(i)};
            end
        end
        return r;
    endfunction

    always_comb begin
        logic [27:0] sh;
        logic [23:0] op;
        logic [2:0] slot;
        logic [4:0] vslot;
        logic [3:0][15:0] nv_keep;
        sh = {din, st.shreg[27:1]};
        op = sh[27:4];
        slot = cw_slot(st.latch_addr);
        vslot = st.bitcnt - 5'h4;
        nv_keep = st.nv;
        next_st = st;

        // the array models flash: only power-up or chip erase restores ones
        if (!por_n || chip_erase) begin
            for (int i = 0; i < 4; i++) begin
                next_st.nv[i] = erased_value(2'(i));
            end
        end

        if (st.busy_cnt != 16'h0) begin
            next_st.busy_cnt = st.busy_cnt - 16'h1;
            if (st.busy_cnt == 16'h1) begin
                next_st.nonvolatile_control_register[`NVM_WR_BIT] = 1'b0;
                if ({1'b0, st.nonvolatile_control_register[14:0]} == `NVM_CW_OP && slot[2]) begin
                    // flash cells can only discharge
                    next_st.nv[slot[1:0]] =
                        st.nv[slot[1:0]] & st.latch;
                end
            end
        end

        unique case (st.state)
            DEV_RELOAD: begin
                next_st.cfg[st.rl_idx] = st.nv[st.rl_idx];
                next_st.rl_idx = st.rl_idx + 2'h1;
                if (st.rl_idx == 2'h3) begin
                    next_st.state = DEV_RUN;
                end
            end
            DEV_RUN: begin
                if (ck_rise) begin
                    next_st.shreg = sh;
                    next_st.bitcnt = st.bitcnt + 5'h1;
                    if (st.bitcnt == 5'd3 && sh[27:24] == `CMD_VIS_OUT) begin
                        next_st.vis_mode = 1'b1;
                    end
                    if (st.bitcnt == 5'd27) begin
                        next_st.bitcnt = 5'h0;
                        next_st.vis_mode = 1'b0;
                        next_st.oe_n = 1'b1;
                        if (!st.vis_mode && sh[3:0] == `CMD_EXEC) begin
                            if (op[23:20] == `MOV_LIT_OPC) begin
                                next_st.wreg[op[3:0]] = op[19:4];
                            end else begin
                                case (op)
                                    `OP_MOV_W10_NVM: begin
                                        // start bit is set only via bset and cleared when the write ends
                                        next_st.nonvolatile_control_register = {st.nonvolatile_control_register[15],
                                            st.wreg[10][14:0]};
                                    end
                                    `OP_MOV_W0_PAGE: begin
                                        next_st.page =
                                            st.wreg[0][7:0];
                                    end
                                    `OP_TBLWTH: begin
                                        // upper byte of a config word
                                        // is not stored
                                        next_st.latch_addr =
                                            {st.page, st.wreg[7]};
                                    end
                                    `OP_TBLWTL: begin
                                        next_st.latch = st.wreg[6];
                                        next_st.latch_addr =
                                            {st.page, st.wreg[7]};
                                    end
                                    `OP_BSET_WR: begin
                                        if (st.busy_cnt == 16'h0) begin
                                            next_st.nonvolatile_control_register[`NVM_WR_BIT] =
                                                1'b1;
                                            next_st.busy_cnt =
                                                16'(`NV_WRITE_CYC);
                                        end
                                    end
                                    `OP_MOV_NVM_W2: begin
                                        next_st.wreg[2] = st.nonvolatile_control_register;
                                    end
                                    `OP_MOV_W2_VIS: begin
                                        next_st.visi = st.wreg[2];
                                    end
                                    default: begin
                                        // nop and the jump to the
                                        // start vector change nothing
                                    end
                                endcase
                            end
                        end
                    end
                end
                // drive only from a falling edge so the programmer has
                // already let go of the pin
                if (ck_fall && st.vis_mode) begin
                    next_st.oe_n = 1'b0;
                    next_st.dout = (vslot < 5'd16) ?
                        st.visi[vslot[3:0]] : 1'b0;
                end
            end
        endcase

        // flash contents survive a plain reset; registers reload from it
        if (!rst_n) begin
            nv_keep = next_st.nv;
            next_st = '0;
            next_st.nv = nv_keep;
            next_st.state = DEV_RELOAD;
            next_st.oe_n = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        st <= next_st;
    end

    assign link.dev_data_out = st.dout;
    assign link.dev_data_oe_n = st.oe_n;
    assign config_word_one = st.cfg[0];
    assign config_word_two = st.cfg[1];
    assign config_word_three = st.cfg[2];
    assign config_word_four = st.cfg[3];
    assign reload_done = (st.state == DEV_RUN);
    assign nv_busy = st.nonvolatile_control_register[`NVM_WR_BIT];
endmodule
`default_nettype wire

// File: rtl/cfg_programmer.sv
// programmer end: writes one configuration word per command, polling
// the write-start bit through the visibility register
// assumes software waits for busy low before the next command
`timescale 1ns/1ps
`default_nettype none
`include "cfg_prog_map.svh"
module cfg_programmer import cfg_prog_pkg::*; #(
    parameter bit HAS_USB = 1'b1
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [3:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [15:0] rdata,
    output logic busy,
    prog_link_if.programmer link
);
    localparam logic [4:0] HALF = 5'(`LINK_HALF_CYC);
    host_s st;
    host_s next_st;
    logic din;

    pin_sync data_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .pin(link.programming_data_pin),
        .level(din),
        .rise(),
        .fall()
    );

    function automatic logic [15:0] fix_reserved(input logic [1:0] i,
                                                 input logic [15:0] v);
        logic [15:0] r;
        r = v;
        unique case (i)
            2'd0: r[`CW1_RSV0_BIT] = 1'b0;
            2'd1: begin
                r[`CW2_RSV1_BIT] = 1'b1;
                r[`CW2_RSV0_BIT] = 1'b0;
                if (!HAS_USB) begin
                    r[`CW2_NOUSB_RSV0_BIT] = 1'b0;
                end
            end
            2'd2: r[`CW3_RSV1_BIT] = 1'b1;
            2'd3: r[`CW4_RSV1_BIT] = 1'b1;
        endcase
        return r;
    endfunction

    // packet {data, code}; sent from bit 0 upward
    function automatic logic [27:0] packet(input logic [4:0] step,
                                           input logic [1:0] i,
                                           input logic [15:0] v);
        logic [23:0] a;
        logic [23:0] op;
        a = cw_addr(i);
        op = `OP_NOP;
        case (step)
            5'd1, 5'd20, 5'd27: op = `OP_GOTO;
            5'd3: op = {`MOV_LIT_OPC, a[15:0], 4'h7};
            5'd4: op = `OP_MOV_LIT_W10;
            5'd5: op = `OP_MOV_W10_NVM;
            5'd6: op = {`MOV_LIT_OPC, 8'h00, a[23:16], 4'h0};
            5'd7: op = `OP_MOV_W0_PAGE;
            5'd8: op = {`MOV_LIT_OPC, fix_reserved(i, v), 4'h6};
            5'd9: op = `OP_CLR_W8;
            5'd11: op = `OP_TBLWTH;
            5'd14: op = `OP_TBLWTL;
            5'd17: op = `OP_BSET_WR;
            5'd22: op = `OP_MOV_NVM_W2;
            5'd23: op = `OP_MOV_W2_VIS;
            default: op = `OP_NOP;
        endcase
        return (step == `STEP_VIS) ? {24'h0, `CMD_VIS_OUT} :
                                     {op, `CMD_EXEC};
    endfunction

    always_comb begin
        logic [4:0] vslot;
        vslot = st.bitcnt - 5'h4;
        next_st = st;
        next_st.rdata = 16'h0;
        if (rd_en) begin
            unique case (addr)
                `REG_CTRL: next_st.rdata = {14'h0, st.idx};
                `REG_DATA: next_st.rdata = st.value;
                `REG_STATUS: next_st.rdata = {14'h0, st.done,
                                              st.state != H_IDLE};
                `REG_READBACK: next_st.rdata = st.readback;
                default: next_st.rdata = 16'h0;
            endcase
        end
        if (wr_en && addr == `REG_DATA) begin
            next_st.value = wdata;
        end
        unique case (st.state)
            H_IDLE: begin
                if (wr_en && addr == `REG_CTRL && wdata[`CTRL_GO_BIT]) begin
                    next_st.idx = wdata[1:0];
                    next_st.step = 5'h0;
                    next_st.bitcnt = 5'h0;
                    next_st.phase = 5'h0;
                    next_st.pkt = packet(5'h0, wdata[1:0], st.value);
                    next_st.dout = next_st.pkt[0];
                    next_st.oe_n = 1'b0;
                    next_st.done = 1'b0;
                    next_st.state = H_LOW;
                end
            end
            H_LOW: begin
                next_st.phase = st.phase + 5'h1;
                if (st.phase == HALF - 5'h1) begin
                    next_st.phase = 5'h0;
                    next_st.clk_out = 1'b1;
                    next_st.state = H_HIGH;
                    if (st.step == `STEP_VIS && st.bitcnt >= 5'd4 &&
                        vslot < 5'd16) begin
                        next_st.rx[vslot[3:0]] = din;
                    end
                end
            end
            H_HIGH: begin
                next_st.phase = st.phase + 5'h1;
                if (st.phase == HALF - 5'h1) begin
                    next_st.phase = 5'h0;
                    next_st.clk_out = 1'b0;
                    next_st.state = H_LOW;
                    next_st.bitcnt = st.bitcnt + 5'h1;
                    if (st.bitcnt == 5'd27) begin
                        next_st.bitcnt = 5'h0;
                        next_st.step = st.step + 5'h1;
                        if (st.step == `STEP_VIS) begin
                            next_st.readback = st.rx;
                        end
                        if (st.step == `STEP_POLL_END &&
                            st.readback[`NVM_WR_BIT]) begin
                            next_st.step = `STEP_POLL;
                        end
                        next_st.pkt = packet(next_st.step, st.idx, st.value);
                    end
                    next_st.dout = next_st.pkt[next_st.bitcnt];
                    // let go while the device answers
                    next_st.oe_n = (next_st.step == `STEP_VIS &&
                                    next_st.bitcnt >= 5'd4);
                    if (st.bitcnt == 5'd27 && st.step == `STEP_LAST) begin
                        next_st.state = H_IDLE;
                        next_st.done = 1'b1;
                        next_st.oe_n = 1'b1;
                        next_st.dout = 1'b0;
                    end
                end
            end
            default: next_st.state = H_IDLE;
        endcase
        if (!rst_n) begin
            next_st = '0;
            next_st.oe_n = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        st <= next_st;
    end

    assign rdata = st.rdata;
    assign busy = (st.state != H_IDLE);
    assign link.programming_clock_pin = st.clk_out;
    assign link.host_data_out = st.dout;
    assign link.host_data_oe_n = st.oe_n;
endmodule
`default_nettype wire

// File: verif/config_word_programming_chk.sv
// checker for the serial link between programmer and device ends
// assumes core_clk samples the link and rst_n is synchronous
`timescale 1ns/1ps
`default_nettype none
module config_word_programming_chk (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic programming_clock_pin,
    input wire logic host_data_out,
    input wire logic host_data_oe_n,
    input wire logic dev_data_out,
    input wire logic dev_data_oe_n,
    input wire logic programming_data_pin
);
    default clocking dclk @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    no_clash_a: assert property (
        host_data_oe_n || dev_data_oe_n) else $error("data pin driven twice");
    clk_high_hold_a: assert property (
        $rose(programming_clock_pin) |-> programming_clock_pin[*8])
        else $error("link clock high too short");
    clk_low_hold_a: assert property (
        $fell(programming_clock_pin) |-> !programming_clock_pin[*8])
        else $error("link clock low too short");
    half_period_a: assert property (
        $rose(programming_clock_pin) |-> ##12 $fell(programming_clock_pin))
        else $error("link clock half period wrong");
    host_data_edge_a: assert property (
        !host_data_oe_n && $changed(host_data_out) |-> !programming_clock_pin)
        else $error("host data moved while clock high");
    dev_data_edge_a: assert property (
        !dev_data_oe_n && $changed(dev_data_out) |-> !programming_clock_pin)
        else $error("device data moved while clock high");
    dev_start_a: assert property (
        $fell(dev_data_oe_n) |-> !programming_clock_pin && host_data_oe_n)
        else $error("device drive began at wrong time");
    dev_end_a: assert property (
        $rose(dev_data_oe_n) |-> programming_clock_pin)
        else $error("device released at wrong time");
    dev_window_a: assert property (
        $fell(dev_data_oe_n) |-> ##[560:570] $rose(dev_data_oe_n))
        else $error("device drive window wrong length");
endmodule
`default_nettype wire

// File: verif/config_word_programming_tb_top.sv
// bench joining programmer and device ends over the link interface
// assumes one core_clk for both ends; software port on the programmer
`timescale 1ns/1ps
`default_nettype none
`include "cfg_prog_map.svh"
module config_word_programming_tb_top;
    logic core_clk, rst_n, por_n, chip_erase, wr_en, rd_en, busy;
    logic reload_done, nv_busy;
    logic [3:0] addr;
    logic [15:0] wdata, rdata, w1, w2, w3, w4;
    int num_errors = 0;
    int cmp_count = 0;
    prog_link_if link_i();
    cfg_device cfg_device_i(.core_clk(core_clk), .rst_n(rst_n),
        .por_n(por_n), .chip_erase(chip_erase), .link(link_i.device),
        .config_word_one(w1), .config_word_two(w2),
        .config_word_three(w3), .config_word_four(w4),
        .reload_done(reload_done), .nv_busy(nv_busy));
    cfg_programmer cfg_programmer_i(.core_clk(core_clk), .rst_n(rst_n),
        .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
        .rdata(rdata), .busy(busy), .link(link_i.programmer));
    config_word_programming_chk config_word_programming_chk_i(
        .core_clk(core_clk), .rst_n(rst_n),
        .programming_clock_pin(link_i.programming_clock_pin),
        .host_data_out(link_i.host_data_out),
        .host_data_oe_n(link_i.host_data_oe_n),
        .dev_data_out(link_i.dev_data_out),
        .dev_data_oe_n(link_i.dev_data_oe_n),
        .programming_data_pin(link_i.programming_data_pin));
    // word two's erased value differs on the variant without usb
    prog_link_if nousb_link_i();
    logic [15:0] nousb_w2;
    assign nousb_link_i.programming_clock_pin = 1'b0;
    assign nousb_link_i.host_data_out = 1'b0;
    assign nousb_link_i.host_data_oe_n = 1'b1;
    cfg_device #(.HAS_USB(1'b0)) cfg_device_nousb_i(.core_clk(core_clk),
        .rst_n(rst_n), .por_n(por_n), .chip_erase(chip_erase),
        .link(nousb_link_i.device), .config_word_one(),
        .config_word_two(nousb_w2), .config_word_three(),
        .config_word_four(), .reload_done(), .nv_busy());
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic check16(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_words(input logic [15:0] e1, e2, e3, e4);
        check16(w1, e1);
        check16(w2, e2);
        check16(w3, e3);
        check16(w4, e4);
    endtask
    task automatic fail_wait();
        num_errors++;
        $display("[ERR] %0t wait limit reached", $time);
        results();
    endtask
    // por or erase reloads the flash with erased values, rst_n alone not
    task automatic do_reset(input logic por, input logic erase);
        @(posedge core_clk);
        rst_n <= 1'b0;
        por_n <= !por;
        chip_erase <= erase;
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        por_n <= 1'b1;
        chip_erase <= 1'b0;
        repeat (5) @(posedge core_clk);
        for (int i = 0; i <= 20; i++) begin
            @(posedge core_clk);
            #1;
            if (i == 20) fail_wait();
            if (reload_done === 1'b1) break;
        end
    endtask
    task automatic rd_check(input logic [3:0] a, input logic [15:0] exp);
        @(posedge core_clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge core_clk);
        rd_en <= 1'b0;
        #1;
        check16(rdata, exp);
    endtask
    // one full word sequence takes some 20k cycles over the link
    task automatic write_word(input logic [1:0] idx, input logic [15:0] v);
        logic seen;
        seen = 1'b0;
        @(posedge core_clk);
        addr <= `REG_DATA;
        wdata <= v;
        wr_en <= 1'b1;
        @(posedge core_clk);
        addr <= `REG_CTRL;
        wdata <= {11'h0, 1'b1, 2'h0, idx};
        @(posedge core_clk);
        wr_en <= 1'b0;
        for (int i = 0; i <= 40000; i++) begin
            @(posedge core_clk);
            #1;
            if (nv_busy === 1'b1) seen = 1'b1;
            if (i == 40000) fail_wait();
            if (busy === 1'b0) break;
        end
        check16({15'h0, seen}, 16'h0001);
        check16({15'h0, nv_busy}, 16'h0000);
    endtask
    task automatic t_defaults();
        do_reset(1'b1, 1'b0);
        check_words(`CW1_ERASED, `CW2_ERASED, `CW34_ERASED, `CW34_ERASED);
        check16(nousb_w2, `CW2_ERASED_NO_USB);
        rd_check(4'hf, 16'h0000);
    endtask
    task automatic t_clear_bits();
        write_word(2'h1, 16'h0f0f);
        check16(w2, `CW2_ERASED);
        rd_check(`REG_STATUS, 16'h0002);
        rd_check(`REG_READBACK, 16'h4003);
        do_reset(1'b0, 1'b0);
        check16(w2, 16'h0f0f);
    endtask
    task automatic t_no_set_back();
        // bits already cleared stay low; reserved bits forced on top
        write_word(2'h1, 16'hf0f0);
        do_reset(1'b0, 1'b0);
        check16(w2, 16'h0004);
    endtask
    task automatic t_word_one();
        write_word(2'h0, 16'h8123);
        do_reset(1'b0, 1'b0);
        check_words(16'h0123, 16'h0004, `CW34_ERASED, `CW34_ERASED);
    endtask
    task automatic t_erase();
        do_reset(1'b0, 1'b1);
        check_words(`CW1_ERASED, `CW2_ERASED, `CW34_ERASED, `CW34_ERASED);
    endtask
    initial begin
        rst_n = 1'b0;
        por_n = 1'b0;
        chip_erase = 1'b0;
        addr = 4'h0;
        wdata = 16'h0000;
        wr_en = 1'b0;
        rd_en = 1'b0;
        t_defaults();
        t_clear_bits();
        t_no_set_back();
        t_word_one();
        t_erase();
        results();
    end
endmodule
`default_nettype wire
